// >>> rtl/flash_program_erase_guard.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module flash_program_erase_guard
	import flash_guard_pkg::*;
#(
	parameter int ADDR_W = 13,
	parameter logic [ADDR_W-1:0] LOCK_BYTE_ADDR = 13'h1FFF,
	parameter logic [ADDR_W-1:0] RESERVED_BASE = 13'h1E00,
	parameter logic [ADDR_W-1:0] RESERVED_TOP = 13'h1FFE,
	parameter int WRITE_COUNT = WRITE_CYCLES,
	parameter int ERASE_COUNT = ERASE_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Core-side access request, same clock domain.
	input wire logic core_req,
	input wire logic core_write,
	input wire logic core_read,
	input wire logic [ADDR_W-1:0] core_addr,
	input wire logic [7:0] core_wdata,
	input wire logic [ADDR_W-1:0] core_pc,
	output logic external_move_write,
	output logic core_stall,
	// Debug port request, same clock domain.
	input wire logic dbg_req,
	input wire logic dbg_write,
	input wire logic dbg_read,
	input wire logic dbg_erase,
	input wire logic dbg_device_erase,
	input wire logic [ADDR_W-1:0] dbg_addr,
	input wire logic [7:0] dbg_wdata,
	output logic dbg_refused,
	// Supply monitor status pins, asynchronous.
	input wire logic supply_mon_enable,
	input wire logic supply_mon_reset_src,
	// Flash array command port.
	output logic flash_write,
	output logic flash_page_erase,
	output logic flash_device_erase,
	output logic [ADDR_W-1:0] flash_addr,
	output logic [7:0] flash_wdata,
	input wire logic [7:0] flash_old_data,
	// Device reset request and lock byte read at reset.
	output logic flash_error_reset,
	input wire logic [7:0] lock_byte_value
);
	localparam int PAGE_W = ADDR_W - PAGE_SHIFT;
	localparam logic [15:0] WRITE_CNT16 = 16'(WRITE_COUNT);
	localparam logic [15:0] ERASE_CNT16 = 16'(ERASE_COUNT);

	// Page number of an address.
	function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] a);
		page_of = a[ADDR_W-1:PAGE_SHIFT];
	endfunction : page_of

	// True when an address lies in a page below the locked count.
	function automatic logic in_locked(input logic [ADDR_W-1:0] a, input logic [7:0] n);
		in_locked = ({{(16-PAGE_W){1'b0}}, page_of(a)} < {8'h00, n});
	endfunction : in_locked

	logic [1:0] control_r; // Write-enable and erase-enable.
	key_state_t key_r; // Key sequencer.
	logic [7:0] lock_count_r; // Pages locked, caught after reset.
	logic lock_caught_r; // Lock count has been taken.
	logic flash_err_flag_r; // Survives flash error resets.
	logic err_req_r; // Flash error reset request.
	logic sm_en_m, sm_en_s, sm_src_m, sm_src_s; // Supply monitor synchronisers.
	logic addr_ok_r, wr_r; // AHB data phase state.
	logic [7:0] addr_r;
	logic busy, op_done, op_start;
	logic [15:0] op_cycles;

	// Lock state derived from the sampled count.
	logic any_locked, lock_page_locked;
	assign any_locked = (lock_count_r != 8'h00);
	assign lock_page_locked = any_locked;

	// Classification of the core access.
	logic c_reserved, c_lockpage, c_lockbyte, c_locked, pc_locked, pc_lockpage;
	assign c_reserved = (core_addr >= RESERVED_BASE) && (core_addr <= RESERVED_TOP);
	assign c_lockpage = page_of(core_addr) == page_of(LOCK_BYTE_ADDR);
	assign c_lockbyte = core_addr == LOCK_BYTE_ADDR;
	assign c_locked = in_locked(core_addr, lock_count_r);
	assign pc_lockpage = page_of(core_pc) == page_of(LOCK_BYTE_ADDR);
	assign pc_locked = in_locked(core_pc, lock_count_r) || (pc_lockpage && lock_page_locked);

	// Core flash write attempts only exist while write-enable is set.
	logic c_wr, c_erase_mode, c_flash_op, c_rd;
	assign c_wr = core_req && core_write && control_r[CTL_WRITE_EN_BIT] && !busy;
	assign c_erase_mode = control_r[CTL_ERASE_EN_BIT];
	assign c_flash_op = c_wr;
	assign c_rd = core_req && core_read && !busy;
	assign external_move_write = core_req && core_write && !control_r[CTL_WRITE_EN_BIT];

	// Permission decision for core accesses.
	logic c_viol;
	always_comb begin
		c_viol = 1'b0;
		if (c_rd || c_flash_op) begin
			if (c_reserved) begin
				c_viol = 1'b1;
			end else if (c_lockpage && lock_page_locked && !pc_locked) begin
				c_viol = 1'b1;
			end else if (c_locked && !pc_locked) begin
				c_viol = 1'b1;
			end
			if (c_flash_op && c_erase_mode && c_lockpage && lock_page_locked) begin
				c_viol = 1'b1;
			end
			if (c_flash_op && !c_erase_mode && c_lockbyte && flash_old_data != ERASED_BYTE) begin
				c_viol = 1'b1;
			end
			if (c_flash_op && !(sm_en_s && sm_src_s)) begin
				c_viol = 1'b1;
			end
		end
	end

	// A core operation is carried out only with the key armed and no violation.
	logic c_go;
	assign c_go = c_flash_op && !c_viol && key_r == KEY_ARMED;

	// Debug port permission: refused accesses have no effect and no reset.
	logic d_reserved, d_lockpage, d_bad, d_go;
	assign d_reserved = (dbg_addr >= RESERVED_BASE) && (dbg_addr <= RESERVED_TOP);
	assign d_lockpage = page_of(dbg_addr) == page_of(LOCK_BYTE_ADDR);
	always_comb begin
		d_bad = d_reserved || in_locked(dbg_addr, lock_count_r) || (d_lockpage && lock_page_locked);
		if (dbg_write && dbg_addr == LOCK_BYTE_ADDR && flash_old_data != ERASED_BYTE) begin
			d_bad = 1'b1;
		end
	end
	assign d_go = dbg_req && !busy && !c_flash_op && (dbg_device_erase || !d_bad);
	assign dbg_refused = dbg_req && !dbg_device_erase && d_bad;

	// The array address follows the requester rather than the go decision.
	// The old byte feeds the permission checks, so steering on the decision
	// would close a combinational loop through the array.
	logic dbg_path;
	assign dbg_path = dbg_req && !c_flash_op;

	// Flash array commands.
	always_comb begin
		flash_write = 1'b0;
		flash_page_erase = 1'b0;
		flash_device_erase = 1'b0;
		flash_addr = dbg_path ? dbg_addr : core_addr;
		flash_wdata = (dbg_path ? dbg_wdata : core_wdata) & flash_old_data;
		if (c_go) begin
			flash_page_erase = c_erase_mode;
			flash_write = !c_erase_mode;
		end else if (d_go) begin
			flash_device_erase = dbg_device_erase;
			flash_page_erase = dbg_erase && !dbg_device_erase;
			flash_write = dbg_write && !dbg_erase && !dbg_device_erase;
		end
	end
	assign op_start = flash_write || flash_page_erase || flash_device_erase;
	// The start cycle already stalls the core, so the timer is loaded one short
	// and the whole stall lasts exactly the programmed count.
	assign op_cycles = (flash_write ? WRITE_CNT16 : ERASE_CNT16) - 16'h0001;

	// Operation timer stalls the core for the fixed duration.
	flash_op_timer #(.WIDTH(16)) u_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(op_start),
		.cycles(op_cycles),
		.busy(busy),
		.done(op_done)
	);
	assign core_stall = busy || op_start;

	// Supply monitor pins pass two flip-flops before use.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sm_en_m <= 1'b0;
			sm_en_s <= 1'b0;
			sm_src_m <= 1'b0;
			sm_src_s <= 1'b0;
		end else begin
			sm_en_m <= supply_mon_enable;
			sm_en_s <= sm_en_m;
			sm_src_m <= supply_mon_reset_src;
			sm_src_s <= sm_src_m;
		end
	end

	// Lock count is caught once after reset; later lock byte writes wait for reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_count_r <= 8'h00;
			lock_caught_r <= 1'b0;
		end else if (!lock_caught_r) begin
			lock_count_r <= ~lock_byte_value;
			lock_caught_r <= 1'b1;
		end
	end

	// Bus decode for register writes.
	logic ahb_take, key_wr, ctl_wr;
	assign ahb_take = hsel && hready && htrans[1];
	assign key_wr = wr_r && addr_ok_r && addr_r == OFS_KEY;
	assign ctl_wr = wr_r && addr_ok_r && addr_r == OFS_CONTROL;

	// AHB address phase capture.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_ok_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= 8'h00;
		end else begin
			addr_ok_r <= ahb_take && haddr[31:8] == 24'h000000 && hsize == 3'h2;
			wr_r <= ahb_take && hwrite;
			addr_r <= haddr[7:0];
		end
	end

	// Control register: bits stay until software clears them.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control_r <= CONTROL_RESET;
		end else if (ctl_wr) begin
			control_r <= hwdata[1:0];
		end
	end

	// Key sequencer: armed only by the two codes in order.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			key_r <= KEY_IDLE;
		end else begin
			unique case (key_r)
				KEY_IDLE: begin
					if (c_flash_op) begin
						key_r <= KEY_DEAD;
					end else if (key_wr) begin
						key_r <= (hwdata[7:0] == KEY_FIRST) ? KEY_HALF : KEY_DEAD;
					end
				end
				KEY_HALF: begin
					if (c_flash_op) begin
						key_r <= KEY_DEAD;
					end else if (key_wr) begin
						key_r <= (hwdata[7:0] == KEY_SECOND) ? KEY_ARMED : KEY_DEAD;
					end
				end
				KEY_ARMED: begin
					if (c_go) begin
						key_r <= KEY_IDLE;
					end else if (key_wr) begin
						key_r <= KEY_DEAD;
					end
				end
				KEY_DEAD: begin
					key_r <= KEY_DEAD;
				end
			endcase
		end
	end

	// Flash error request; the flag itself is cleared only by a software write of zero.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_req_r <= 1'b0;
		end else begin
			err_req_r <= c_viol;
		end
	end
	assign flash_error_reset = err_req_r;

	// Flag is set by the error; only a software write of zero clears it.
	// The error request comes back as hresetn, so the flag has no reset branch:
	// it must survive that reset to tell software why the reset happened.
	// Its power-up value is undefined until the first error or write.
	always_ff @(posedge hclk) begin
		if (c_viol) begin
			flash_err_flag_r <= 1'b1;
		end else if (wr_r && addr_ok_r && addr_r == OFS_RESET_SOURCE) begin
			flash_err_flag_r <= hwdata[RSRC_FLASH_ERR_BIT];
		end
	end

	// Read data mux.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (ahb_take && !hwrite) begin
			hrdata <= 32'h00000000;
			unique case (haddr[7:0])
				OFS_CONTROL: hrdata[1:0] <= control_r;
				OFS_STATUS: begin
					hrdata[STS_ARMED_BIT] <= key_r == KEY_ARMED;
					hrdata[STS_DISABLED_BIT] <= key_r == KEY_DEAD;
					hrdata[STS_BUSY_BIT] <= busy;
					hrdata[STS_HALF_BIT] <= key_r == KEY_HALF;
					hrdata[STS_ERR_BIT] <= op_done;
				end
				OFS_LOCK_BYTE: hrdata[7:0] <= lock_count_r;
				OFS_RESET_SOURCE: hrdata[RSRC_FLASH_ERR_BIT] <= flash_err_flag_r;
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	// The registers answer at once, so the bus never waits and never errs.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule : flash_program_erase_guard

// >>> shared/flash_guard_pkg.sv
package flash_guard_pkg;
	// Register byte offsets on the bus.
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_KEY = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_LOCK_BYTE = 8'h0C;
	localparam logic [7:0] OFS_RESET_SOURCE = 8'h10;
	// Field positions of the control register.
	localparam int CTL_WRITE_EN_BIT = 0;
	localparam int CTL_ERASE_EN_BIT = 1;
	// Field positions of the status and reset source registers.
	localparam int STS_ARMED_BIT = 0;
	localparam int STS_DISABLED_BIT = 1;
	localparam int STS_BUSY_BIT = 2;
	localparam int STS_HALF_BIT = 3;
	localparam int STS_ERR_BIT = 4;
	localparam int RSRC_FLASH_ERR_BIT = 6;
	// Reset and erased values.
	localparam logic [1:0] CONTROL_RESET = 2'h0;
	localparam logic [7:0] LOCK_BYTE_RESET = 8'hFF;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// Key codes.
	localparam logic [7:0] KEY_FIRST = 8'hA5;
	localparam logic [7:0] KEY_SECOND = 8'hF1;
	// Page geometry.
	localparam int PAGE_BYTES = 512;
	localparam int PAGE_SHIFT = 9;
	// Write and erase durations and cycle counts at 40 MHz.
	localparam int CLK_MHZ = 40;
	localparam int WRITE_TIME_US = 20;
	localparam int ERASE_TIME_US = 100;
	localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
	localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
	// Key sequencer states.
	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_HALF = 2'b01,
		KEY_ARMED = 2'b10,
		KEY_DEAD = 2'b11
	} key_state_t;
endpackage : flash_guard_pkg

// >>> rtl/flash_op_timer.sv
`timescale 1ns/1ps
// Counts a write or erase duration and reports busy until it elapses.
module flash_op_timer
	import flash_guard_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic [WIDTH-1:0] cycles,
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] count_r; // Cycles still to run.

	// Load on start, count down, pulse done in the cycle after the last busy cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_r <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && count_r == '0) begin
				count_r <= cycles;
			end else if (count_r != '0) begin
				count_r <= count_r - 1'b1;
				done <= (count_r == {{(WIDTH-1){1'b0}}, 1'b1});
			end
		end
	end

	// Busy is decoded from the count, so it rises the cycle after start; the guard adds start itself to the stall.
	assign busy = (count_r != '0);
endmodule : flash_op_timer

// >>> verification/flash_array_model.sv
`timescale 1ns/1ps
// Behavioural flash array facing the guard's command port.
// Commands land after the edge that samples them, so the guard still sees the
// old byte at that edge; reads are combinational.
module flash_array_model (
	input wire logic hclk,
	input wire logic flash_write,
	input wire logic flash_page_erase,
	input wire logic flash_device_erase,
	input wire logic [12:0] flash_addr,
	input wire logic [7:0] flash_wdata,
	output logic [7:0] flash_old_data,
	output logic [7:0] lock_byte_value
);
	logic [7:0] mem [8192]; // Byte store, starts fully erased.
	initial foreach (mem[i]) mem[i] = 8'hFF;
	// A real array can only clear bits, so a write is ANDed in here as well.
	always @(posedge hclk) begin
		if (flash_device_erase) begin
			foreach (mem[i]) mem[i] <= 8'hFF;
		end else if (flash_page_erase) begin
			for (int i = 0; i < 512; i++) begin
				mem[{flash_addr[12:9], i[8:0]}] <= 8'hFF;
			end
		end else if (flash_write) begin
			mem[flash_addr] <= mem[flash_addr] & flash_wdata;
		end
	end
	assign flash_old_data = mem[flash_addr];
	assign lock_byte_value = mem[13'h1FFF];
endmodule : flash_array_model

// >>> verification/flash_guard_chk.sv
`timescale 1ns/1ps
// Port-level checker for the guard; each property ties an output to its cause.
module flash_guard_chk #(
	parameter int ADDR_W = 13,
	parameter int ERASE_COUNT = 8,
	parameter logic [12:0] RESERVED_BASE = 13'h1E00,
	parameter logic [12:0] RESERVED_TOP = 13'h1FFE
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic core_req,
	input wire logic core_write,
	input wire logic core_read,
	input wire logic [ADDR_W-1:0] core_addr,
	input wire logic external_move_write,
	input wire logic core_stall,
	input wire logic dbg_req,
	input wire logic dbg_device_erase,
	input wire logic [ADDR_W-1:0] dbg_addr,
	input wire logic dbg_refused,
	input wire logic supply_mon_enable,
	input wire logic flash_write,
	input wire logic flash_page_erase,
	input wire logic flash_device_erase,
	input wire logic [7:0] flash_wdata,
	input wire logic [7:0] flash_old_data,
	input wire logic flash_error_reset
);
	// Longest stall plus slack for the launch cycle.
	localparam int STALL_MAX = ERASE_COUNT + 2;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_WRITE_CLEARS_ONLY: assert property (flash_write |-> (flash_wdata & ~flash_old_data) == 8'h00)
		else $error("flash write would set a bit");
	AST_OP_STALLS: assert property ((flash_write || flash_page_erase) |-> core_stall ##1 core_stall)
		else $error("operation without core stall");
	AST_STALL_ENDS: assert property ($rose(core_stall) |-> ##[1:STALL_MAX] !core_stall)
		else $error("core stall too long");
	AST_DBG_SILENT: assert property (dbg_refused && !core_req |->
		!(flash_write || flash_page_erase || flash_device_erase) ##1 !flash_error_reset)
		else $error("refused debug access had an effect");
	AST_DEV_ERASE_SRC: assert property (flash_device_erase |-> dbg_req && dbg_device_erase)
		else $error("device erase without debug request");
	AST_RESERVED_ERR: assert property (core_req && (core_read || core_write) &&
		!external_move_write && !core_stall &&
		core_addr inside {[RESERVED_BASE:RESERVED_TOP]} |=> flash_error_reset)
		else $error("reserved core access without error reset");
	AST_DBG_RESERVED: assert property (dbg_req && !dbg_device_erase && !core_req &&
		dbg_addr inside {[RESERVED_BASE:RESERVED_TOP]} |-> dbg_refused)
		else $error("reserved debug access not refused");
	AST_ERR_PULSE: assert property (flash_error_reset |=> !flash_error_reset)
		else $error("error reset longer than one cycle");
	AST_MOVE_TO_RAM: assert property (external_move_write && !dbg_req |-> !flash_write && !flash_page_erase)
		else $error("data memory write reached flash");
	AST_SUPPLY_ERR: assert property (core_req && core_write && !external_move_write &&
		!core_stall && !supply_mon_enable && !$past(supply_mon_enable) &&
		!$past(supply_mon_enable, 2) && !$past(supply_mon_enable, 3) |=> flash_error_reset)
		else $error("flash write with supply monitor off not stopped");
endmodule : flash_guard_chk
bind flash_program_erase_guard flash_guard_chk #(.ADDR_W(ADDR_W), .ERASE_COUNT(ERASE_COUNT),
	.RESERVED_BASE(RESERVED_BASE), .RESERVED_TOP(RESERVED_TOP)) chk_u (.hclk, .hresetn,
	.core_req, .core_write, .core_read, .core_addr, .external_move_write, .core_stall,
	.dbg_req, .dbg_device_erase, .dbg_addr, .dbg_refused, .supply_mon_enable, .flash_write,
	.flash_page_erase, .flash_device_erase, .flash_wdata, .flash_old_data, .flash_error_reset);

// >>> verification/flash_program_erase_guard_bench.sv
`timescale 1ns/1ps
// Self-checking bench: registers over the bus, core and debug requests at the ports.
module flash_program_erase_guard_bench
	import flash_guard_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, core_req, core_write, core_read, dbg_req;
	logic dbg_write, dbg_read, dbg_erase, dbg_device_erase, supply_mon_enable, supply_mon_reset_src;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [12:0] core_addr, core_pc, dbg_addr, flash_addr;
	logic [7:0] core_wdata, dbg_wdata, flash_wdata, flash_old_data, lock_byte_value;
	logic hreadyout, hresp, external_move_write, core_stall, dbg_refused, flash_write;
	logic flash_page_erase, flash_device_erase, flash_error_reset;
	wire hready = hreadyout; // Single slave drives the bus ready.
	int n_mismatch = 0;
	int n_checks = 0;
	int n_fw = 0, n_fe = 0, n_err = 0, n_stall = 0, n_xm = 0; // Event counters.
	logic [31:0] r;
	flash_program_erase_guard #(.WRITE_COUNT(8), .ERASE_COUNT(8)) dut_u (.hclk, .hresetn, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
		.core_req, .core_write, .core_read, .core_addr, .core_wdata, .core_pc,
		.external_move_write, .core_stall, .dbg_req, .dbg_write, .dbg_read, .dbg_erase,
		.dbg_device_erase, .dbg_addr, .dbg_wdata, .dbg_refused, .supply_mon_enable,
		.supply_mon_reset_src, .flash_write, .flash_page_erase, .flash_device_erase, .flash_addr,
		.flash_wdata, .flash_old_data, .flash_error_reset, .lock_byte_value);
	flash_array_model model_u (.hclk, .flash_write, .flash_page_erase, .flash_device_erase,
		.flash_addr, .flash_wdata, .flash_old_data, .lock_byte_value);
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	// Counting at the edge sees the values of the cycle just ending.
	always @(posedge hclk) begin
		n_fw += flash_write;
		n_fe += flash_page_erase;
		n_err += flash_error_reset;
		n_stall += core_stall;
		n_xm += external_move_write;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// One single AHB transfer; every task but check returns just after a rising edge.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb
	task automatic keys(input logic [7:0] a, input logic [7:0] b);
		ahb(1'b1, OFS_KEY, {24'h000000, a});
		ahb(1'b1, OFS_KEY, {24'h000000, b});
	endtask : keys
	task automatic core_op(input logic w, input logic [12:0] a, input logic [12:0] pc);
		core_req <= 1'b1;
		core_write <= w;
		core_read <= !w;
		core_addr <= a;
		core_pc <= pc;
		core_wdata <= 8'h5A;
		@(posedge hclk);
		core_req <= 1'b0;
		core_write <= 1'b0;
		core_read <= 1'b0;
		repeat (12) @(posedge hclk);
	endtask : core_op
	// k is {device erase, erase, write, read}; the refusal is sampled mid-cycle.
	task automatic dbg(input logic [3:0] k, input logic [12:0] a, input logic exp);
		dbg_req <= 1'b1;
		{dbg_device_erase, dbg_erase, dbg_write, dbg_read} <= k;
		dbg_addr <= a;
		@(negedge hclk);
		check("dbg_refused", {31'h0, dbg_refused}, {31'h0, exp});
		@(posedge hclk);
		dbg_req <= 1'b0;
		{dbg_device_erase, dbg_erase, dbg_write, dbg_read} <= 4'h0;
		repeat (2) @(posedge hclk);
	endtask : dbg
	task automatic do_reset();
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
	endtask : do_reset
	task automatic t_regs();
		ahb(1'b0, OFS_CONTROL, 32'h0);
		check("control_reset", r, 32'h0);
		ahb(1'b0, OFS_LOCK_BYTE, 32'h0);
		check("lock_count_free", r, 32'h0);
		ahb(1'b1, OFS_CONTROL, 32'h3);
		ahb(1'b0, OFS_CONTROL, 32'h0);
		check("control_kept", r, 32'h3);
		ahb(1'b0, 8'h20, 32'h0);
		check("unmapped", r, 32'h0);
		$display("test regs done");
	endtask : t_regs
	task automatic t_write();
		int f0, s0;
		do_reset();
		f0 = n_fw;
		s0 = n_stall;
		ahb(1'b1, OFS_CONTROL, 32'h1);
		keys(KEY_FIRST, KEY_SECOND);
		core_op(1'b1, 13'h0400, 13'h0A00);
		check("byte", {24'h0, model_u.mem[13'h0400]}, 32'h5A);
		check("writes", n_fw - f0, 1);
		check("stall", n_stall - s0, 8);
		core_op(1'b1, 13'h0401, 13'h0A00);
		check("rearm", n_fw - f0, 1);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check("disabled", {31'h0, r[STS_DISABLED_BIT]}, 32'h1);
		$display("test write done");
	endtask : t_write
	task automatic t_erase();
		int e0, x0;
		do_reset();
		model_u.mem[13'h0805] = 8'h00;
		model_u.mem[13'h09FF] = 8'h00;
		model_u.mem[13'h0A00] = 8'h00;
		e0 = n_fe;
		x0 = n_xm;
		ahb(1'b1, OFS_CONTROL, 32'h2);
		core_op(1'b1, 13'h0810, 13'h0A00);
		check("to_ram", n_xm - x0, 1);
		ahb(1'b1, OFS_CONTROL, 32'h3);
		keys(KEY_FIRST, KEY_SECOND);
		core_op(1'b1, 13'h0810, 13'h0A00);
		check("erases", n_fe - e0, 1);
		check("lo", {24'h0, model_u.mem[13'h0805]}, {24'h0, ERASED_BYTE});
		check("hi", {24'h0, model_u.mem[13'h09FF]}, {24'h0, ERASED_BYTE});
		check("next", {24'h0, model_u.mem[13'h0A00]}, 32'h0);
		$display("test erase done");
	endtask : t_erase
	task automatic t_badkey();
		int f0;
		do_reset();
		f0 = n_fw;
		ahb(1'b1, OFS_CONTROL, 32'h1);
		keys(KEY_FIRST, 8'h00);
		keys(KEY_FIRST, KEY_SECOND);
		core_op(1'b1, 13'h0C00, 13'h0A00);
		check("dead_key", n_fw - f0, 0);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check("disabled", {31'h0, r[STS_DISABLED_BIT]}, 32'h1);
		$display("test bad key done");
	endtask : t_badkey
	task automatic t_lock();
		int e0;
		model_u.mem[13'h1FFF] = 8'hFD;
		do_reset();
		ahb(1'b0, OFS_LOCK_BYTE, 32'h0);
		check("lock_count", r, 32'h2);
		dbg(4'h1, 13'h0010, 1'b1);
		dbg(4'h1, 13'h0400, 1'b0);
		dbg(4'h1, 13'h1FFF, 1'b1);
		dbg(4'h2, 13'h1E10, 1'b1);
		e0 = n_err;
		core_op(1'b0, 13'h0210, 13'h0010);
		check("locked_code", n_err - e0, 0);
		core_op(1'b0, 13'h0210, 13'h0A00);
		check("unlocked_code", n_err - e0, 1);
		do_reset();
		ahb(1'b0, OFS_RESET_SOURCE, 32'h0);
		check("err_flag", {31'h0, r[RSRC_FLASH_ERR_BIT]}, 32'h1);
		core_op(1'b0, 13'h1FFF, 13'h0A00);
		check("lock_read", n_err - e0, 2);
		do_reset();
		core_op(1'b0, 13'h1E10, 13'h0010);
		check("reserved", n_err - e0, 3);
		do_reset();
		ahb(1'b1, OFS_CONTROL, 32'h3);
		keys(KEY_FIRST, KEY_SECOND);
		core_op(1'b1, 13'h1FFF, 13'h0010);
		check("lock_erase", n_err - e0, 4);
		do_reset();
		dbg(4'h8, 13'h0000, 1'b0);
		check("dev_erase", {24'h0, model_u.mem[13'h1FFF]}, 32'hFF);
		do_reset();
		ahb(1'b0, OFS_LOCK_BYTE, 32'h0);
		check("unlocked", r, 32'h0);
		ahb(1'b1, OFS_CONTROL, 32'h1);
		keys(KEY_FIRST, KEY_SECOND);
		core_op(1'b1, 13'h1FFF, 13'h0A00);
		ahb(1'b0, OFS_LOCK_BYTE, 32'h0);
		check("lock_deferred", r, 32'h0);
		keys(KEY_FIRST, KEY_SECOND);
		core_op(1'b1, 13'h1FFF, 13'h0A00);
		check("lock_rewrite", n_err - e0, 5);
		dbg(4'h8, 13'h0000, 1'b0);
		$display("test lock done");
	endtask : t_lock
	task automatic t_supply();
		int e0;
		do_reset();
		e0 = n_err;
		supply_mon_enable <= 1'b0;
		ahb(1'b1, OFS_CONTROL, 32'h1);
		keys(KEY_FIRST, KEY_SECOND);
		core_op(1'b1, 13'h0C10, 13'h0A00);
		check("supply", n_err - e0, 1);
		supply_mon_enable <= 1'b1;
		do_reset();
		$display("test supply done");
	endtask : t_supply
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict
	// Inputs start quiet with the supply monitor on, in reset.
	initial begin
		{hresetn, hsel, hwrite, core_req, core_write, core_read, dbg_req, dbg_write} = 8'h00;
		{dbg_read, dbg_erase, dbg_device_erase} = 3'h0;
		{supply_mon_enable, supply_mon_reset_src} = 2'h3;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
		{core_addr, core_pc, dbg_addr, core_wdata, dbg_wdata} = {39'h0, 16'h0};
		do_reset();
		t_regs();
		t_write();
		t_erase();
		t_badkey();
		t_lock();
		t_supply();
		print_verdict();
	end
	// The tests need a few hundred cycles; this cuts a hang short.
	initial begin
		#(25 * 20000);
		n_mismatch++;
		print_verdict();
	end
endmodule : flash_program_erase_guard_bench
